// [rtl/gpio_bank.sv]
module gpio_bank
	import gpio_pkg::*;
(
	// clock and reset
	input  wire logic                       core_clk_in,
	input  wire logic                       rst_in,
	input  wire logic                       ce_in,
	input  wire logic                       init_done_in,
	// configuration
	input  wire gpio_pkg::pin_cfg_t         cfg_in [NUM_PINS],
	input  wire logic [1:0]                 vdd_sel_in,
	input  wire logic                       alarm_en_in,
	input  wire logic [NUM_STICKY-1:0]      sticky_clear_in,
	input  wire logic [NUM_STAGES-1:0]      stage_full_in,
	input  wire logic [LOOP_W-1:0]          loop_sel_in [NUM_PINS],
	// live alarms
	input  wire gpio_pkg::alarm_live_t      live_in,
	// pins
	input  wire logic [NUM_PINS-1:0]        pin_in,
	output logic      [NUM_PINS-1:0]        pin_out,
	output logic      [NUM_PINS-1:0]        pin_oe_n_out,
	output logic      [NUM_PINS-1:0]        pin_pull_up_out,
	output logic      [NUM_PINS-1:0]        pin_pull_en_out,
	output logic      [1:0]                 vdd_level_out,
	// status
	output logic      [NUM_PINS-1:0]        pin_status_out,
	output logic      [NUM_STICKY-1:0]      sticky_out,
	// targets
	output logic      [NUM_OUTS-1:0]        clk_out_dis_out,
	output logic      [NUM_STAGES-1:0]      clk_in_sel_out,
	output logic      [NUM_PINS-1:0]        clk_in_pin_out,
	output gpio_pkg::loop_ctl_t             loop_ctl_out
);
	logic [NUM_PINS-1:0]   sync_w;
	logic [NUM_PINS-1:0]   rise_w;
	logic [NUM_STICKY-1:0] sticky_w;
	logic [NUM_PINS-1:0]   drive_w;
	logic [NUM_PINS-1:0]   is_out_w;
	logic [NUM_PINS-1:0]   val_w;
	logic [NUM_OUTS-1:0]   dis_w;
	logic [NUM_STAGES-1:0] stage_w;
	logic [NUM_PINS-1:0]   clkpin_w;
	loop_ctl_t             loop_w;
	logic [NUM_PINS-1:0]   pin_reg;
	logic [NUM_PINS-1:0]   oe_n_reg;
	logic [NUM_PINS-1:0]   status_reg;
	logic [NUM_OUTS-1:0]   dis_reg;
	logic [NUM_STAGES-1:0] stage_reg;
	logic [NUM_PINS-1:0]   clkpin_reg;
	loop_ctl_t             loop_reg;
	logic [NUM_PINS-1:0]   pu_reg;
	logic [NUM_PINS-1:0]   pe_reg;
	logic [1:0]            vdd_reg;
	logic [NUM_STICKY-1:0] sticky_reg;

	function automatic logic mode_is_output(input pin_mode_t m);
		return (m == MODE_GP_OUT) || (m == MODE_LOS) || (m == MODE_LOL_LIVE) || (m == MODE_LOL_STICKY)
			|| (m == MODE_HO_LIVE) || (m == MODE_HO_STICKY) || (m == MODE_ALERT);
	endfunction

	function automatic logic sticky_bit(input logic [NUM_STICKY-1:0] s, input int idx);
		return s[idx];
	endfunction

	pin_sync u_sync (
		.core_clk_in (core_clk_in),
		.rst_in      (rst_in),
		.ce_in       (ce_in),
		.pin_raw_in  (pin_in),
		.pin_sync_out(sync_w),
		.pin_rise_out(rise_w)
	);

	sticky_alarms u_sticky (
		.core_clk_in(core_clk_in),
		.rst_in     (rst_in),
		.ce_in      (ce_in),
		.live_in    (live_in),
		.alarm_en_in(alarm_en_in),
		.clear_in   (sticky_clear_in),
		.sticky_out (sticky_w)
	);

	// per-pin function decode
	always_comb begin
		dis_w   = '0;
		stage_w = '0;
		clkpin_w = '0;
		loop_w  = '0;
		for (int p = 0; p < NUM_PINS; p++) begin
			logic     active;
			logic     raw;
			int       ls;
			int       rs;
			active      = init_done_in & cfg_in[p].enable;
			ls          = int'(loop_sel_in[p]);
			rs          = int'(cfg_in[p].sel);
			raw         = 1'b0;
			is_out_w[p] = active & mode_is_output(cfg_in[p].mode);
			case (cfg_in[p].mode)
				MODE_GP_OUT:     raw = cfg_in[p].out_level;
				MODE_LOS:        raw = live_in.los[rs] ^ cfg_in[p].invert;
				MODE_LOL_LIVE:   raw = live_in.unlocked[ls];
				MODE_LOL_STICKY: raw = sticky_bit(sticky_w, NUM_LOOPS + ls) ^ cfg_in[p].invert;
				MODE_HO_LIVE:    raw = live_in.holdover[ls];
				MODE_HO_STICKY:  raw = sticky_bit(sticky_w, ls) ^ cfg_in[p].invert;
				MODE_ALERT:      raw = (|(sticky_w & cfg_in[p].alert_mask)) ^ cfg_in[p].invert;
				MODE_OUT_DIS: begin
					if (active && sync_w[p]) begin
						dis_w = dis_w | cfg_in[p].out_mask;
					end
				end
				MODE_CLK_IN: begin
					if (active && !stage_full_in[rs % NUM_STAGES]) begin
						stage_w[rs % NUM_STAGES] = 1'b1;
						clkpin_w[p] = sync_w[p];
					end
				end
				MODE_MAN_SEL:    loop_w.man_high[ls] = loop_w.man_high[ls] | (active & sync_w[p]);
				MODE_DCO_INC:    loop_w.inc[ls] = loop_w.inc[ls] | (active & rise_w[p]);
				MODE_DCO_DEC:    loop_w.dec[ls] = loop_w.dec[ls] | (active & rise_w[p]);
				MODE_DISQUAL:    loop_w.disqual[ls] = loop_w.disqual[ls] | (active & sync_w[p]);
				default:         raw = 1'b0;
			endcase
			val_w[p] = raw;
			// open drain only pulls low; high releases the pin
			drive_w[p] = is_out_w[p] & (~cfg_in[p].open_drain | ~raw);
		end
	end

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			pin_reg    <= '0;
			oe_n_reg   <= '1;
			status_reg <= '0;
			dis_reg    <= '0;
			stage_reg  <= '0;
			clkpin_reg <= '0;
			loop_reg   <= '0;
			pu_reg     <= {NUM_PINS{PULL_UP_DEFAULT}};
			pe_reg     <= '1;
			vdd_reg    <= VDD_3V3;
			sticky_reg <= '0;
		end else if (ce_in) begin
			pin_reg    <= val_w & is_out_w;
			oe_n_reg   <= ~drive_w;
			status_reg <= sync_w;
			dis_reg    <= dis_w;
			stage_reg  <= stage_w;
			clkpin_reg <= clkpin_w;
			loop_reg   <= loop_w;
			vdd_reg    <= vdd_sel_in;
			sticky_reg <= sticky_w;
			for (int p = 0; p < NUM_PINS; p++) begin
				pu_reg[p] <= cfg_in[p].pull_up;
			end
		end
	end

	assign pin_out         = pin_reg;
	assign pin_oe_n_out    = oe_n_reg;
	assign pin_status_out  = status_reg;
	assign sticky_out      = sticky_reg;
	assign clk_out_dis_out = dis_reg;
	assign clk_in_sel_out  = stage_reg;
	assign clk_in_pin_out  = clkpin_reg;
	assign loop_ctl_out    = loop_reg;
	assign pin_pull_up_out = pu_reg;
	assign pin_pull_en_out = pe_reg;
	assign vdd_level_out   = vdd_reg;
endmodule

// [rtl/gpio_pkg.sv]
// Contract
// - unconfigured pins act as inputs; sampled level readable in a status word.
// - general output mode drives the host-written output register level.
// - pin functions take effect only after the reset sequence completes.
// - pins with identical alarm configuration drive identical values.
// - signal-loss mode drives high while selected monitor alarms; invertible.
// - signal-loss output follows the live alarm, never latched.
// - live lock-loss mode is high while selected loop is unlocked.
// - sticky lock-loss asserts on lock change, invertible, held until host clear.
// - live holdover mode is high while selected loop is in holdover.
// - sticky holdover asserts on holdover change, invertible, held until host clear.
// - alert mode outputs OR of enabled sticky bits, invertible.
// - output-disable input high disables selected output clocks; low enables them.
// - each disable pin controls any register-chosen subset of output clocks.
// - pin may feed its input stage as clock unless stage has two references.
// - manual select pin high picks higher priority reference, low the lower.
// - rising edge in increment mode steps the chosen oscillator up.
// - rising edge in decrement mode steps the chosen oscillator down.
// - disqualify mode high level disqualifies the chosen reference for a loop.
// - one global field records the pin supply voltage for all pins.
// - per-pin enable; output pins choose open-drain or push-pull drive.
// - per-pin pull selection, pull-up by default, else pull-down.
// - every sticky bit sets on any change of its live alarm.
// - alert output may lag up to 200 us after clearing all sticky bits.
// - a global alarm enable masks all alarm sources at once; code gates only sticky-bit setting, live-mode pins stay unmasked.
package gpio_pkg;
	localparam int NUM_PINS    = 16;
	localparam int NUM_REFS    = 16;
	localparam int NUM_LOOPS   = 8;
	localparam int NUM_OUTS    = 16;
	localparam int NUM_STAGES  = 8;
	localparam int SEL_W       = 4;
	localparam int LOOP_W      = 3;
	localparam int NUM_STICKY  = NUM_REFS + 2 * NUM_LOOPS;
	localparam int CLK_FREQ_HZ = 10_000_000;
	localparam int ALERT_LAG_US = 200;
	localparam int ALERT_LAG_CYC = (ALERT_LAG_US * (CLK_FREQ_HZ / 1_000_000));
	localparam logic [1:0] VDD_1V5 = 2'h0;
	localparam logic [1:0] VDD_1V8 = 2'h1;
	localparam logic [1:0] VDD_2V5 = 2'h2;
	localparam logic [1:0] VDD_3V3 = 2'h3;
	localparam logic       PULL_UP_DEFAULT = 1'b1;

	typedef enum logic [3:0] {
		MODE_GP_IN,
		MODE_GP_OUT,
		MODE_LOS,
		MODE_LOL_LIVE,
		MODE_LOL_STICKY,
		MODE_HO_LIVE,
		MODE_HO_STICKY,
		MODE_ALERT,
		MODE_OUT_DIS,
		MODE_CLK_IN,
		MODE_MAN_SEL,
		MODE_DCO_INC,
		MODE_DCO_DEC,
		MODE_DISQUAL
	} pin_mode_t;

	typedef struct packed {
		pin_mode_t                  mode;
		logic                       enable;
		logic                       open_drain;
		logic                       pull_up;
		logic                       invert;
		logic                       out_level;
		logic [SEL_W-1:0]           sel;
		logic [NUM_OUTS-1:0]        out_mask;
		logic [NUM_STICKY-1:0]      alert_mask;
	} pin_cfg_t;

	typedef struct packed {
		logic [NUM_REFS-1:0]  los;
		logic [NUM_LOOPS-1:0] unlocked;
		logic [NUM_LOOPS-1:0] holdover;
	} alarm_live_t;

	typedef struct packed {
		logic [NUM_LOOPS-1:0] inc;
		logic [NUM_LOOPS-1:0] dec;
		logic [NUM_LOOPS-1:0] man_high;
		logic [NUM_LOOPS-1:0] disqual;
	} loop_ctl_t;
endpackage

// [rtl/pin_sync.sv]
module pin_sync
	import gpio_pkg::*;
(
	// clock and reset
	input  wire logic                core_clk_in,
	input  wire logic                rst_in,
	input  wire logic                ce_in,
	// pins
	input  wire logic [NUM_PINS-1:0] pin_raw_in,
	output logic      [NUM_PINS-1:0] pin_sync_out,
	output logic      [NUM_PINS-1:0] pin_rise_out
);
	logic [NUM_PINS-1:0] meta_reg;
	logic [NUM_PINS-1:0] sync_reg;
	logic [NUM_PINS-1:0] last_reg;

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			// reset to the pulled-up idle level, no false rise
			meta_reg <= '1;
			sync_reg <= '1;
			last_reg <= '1;
		end else if (ce_in) begin
			meta_reg <= pin_raw_in;
			sync_reg <= meta_reg;
			last_reg <= sync_reg;
		end
	end

	assign pin_sync_out = sync_reg;
	assign pin_rise_out = sync_reg & ~last_reg;
endmodule

// [rtl/sticky_alarms.sv]
module sticky_alarms
	import gpio_pkg::*;
(
	// clock and reset
	input  wire logic                  core_clk_in,
	input  wire logic                  rst_in,
	input  wire logic                  ce_in,
	// live alarms and controls
	input  wire gpio_pkg::alarm_live_t live_in,
	input  wire logic                  alarm_en_in,
	input  wire logic [NUM_STICKY-1:0] clear_in,
	// sticky status
	output logic      [NUM_STICKY-1:0] sticky_out
);
	logic [NUM_STICKY-1:0] live_reg;
	logic [NUM_STICKY-1:0] sticky_reg;
	logic                  primed_reg;
	wire  [NUM_STICKY-1:0] live_now;
	wire  [NUM_STICKY-1:0] change;

	assign live_now = live_in;
	assign change   = (live_now ^ live_reg) & {NUM_STICKY{alarm_en_in & primed_reg}};

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			live_reg   <= '0;
			sticky_reg <= '0;
			primed_reg <= 1'b0;
		end else if (ce_in) begin
			live_reg   <= live_now;
			primed_reg <= 1'b1;
			sticky_reg <= (sticky_reg & ~clear_in) | change;
		end
	end

	assign sticky_out = sticky_reg;
endmodule

// [verification/board_model.sv]
module board_model
	import gpio_pkg::*;
(
	// device side
	input wire logic [NUM_PINS-1:0]	pin_out_in,
	input wire logic [NUM_PINS-1:0]	oe_n_in,
	input wire logic [NUM_PINS-1:0]	pull_up_in,
	// board drivers
	input wire logic [NUM_PINS-1:0]	drv_in,
	input wire logic [NUM_PINS-1:0]	drv_en_in,
	// resolved wire
	output logic [NUM_PINS-1:0]	wire_out
);
	timeunit 1ns;
	timeprecision 1ns;
	// released pins not driven by the board fall to the selected pull
	assign wire_out = (~oe_n_in & pin_out_in) | (oe_n_in & ((drv_en_in & drv_in) | (~drv_en_in & pull_up_in)));
endmodule

// [verification/gpio_bank_chk.sv]
module gpio_bank_chk
	import gpio_pkg::*;
(
	// clock and reset
	input wire logic	core_clk_in,
	input wire logic	rst_in,
	input wire logic	ce_in,
	input wire logic	init_done_in,
	// controls
	input wire gpio_pkg::pin_cfg_t	cfg_in [NUM_PINS],
	input wire logic	alarm_en_in,
	input wire logic [NUM_STICKY-1:0]	sticky_clear_in,
	input wire gpio_pkg::alarm_live_t	live_in,
	// outputs
	input wire logic [NUM_PINS-1:0]	pin_out,
	input wire logic [NUM_PINS-1:0]	pin_oe_n_out,
	input wire logic [NUM_STICKY-1:0]	sticky_out,
	input wire gpio_pkg::loop_ctl_t	loop_ctl_out
);
	timeunit 1ns;
	timeprecision 1ns;
	alarm_live_t	live_q;
	logic [NUM_STICKY-1:0]	chg;
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) live_q <= '0;
		else live_q <= live_in;
	end
	assign chg = live_in ^ live_q;
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (rst_in);
	AST_INIT: assert property (!init_done_in && ce_in |=> &pin_oe_n_out) else $error("init drive");
	AST_INC: assert property (ce_in |=> (loop_ctl_out.inc & $past(loop_ctl_out.inc)) == '0) else $error("inc");
	for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin
		wire act = init_done_in && ce_in && cfg_in[g].enable;
		wire alr = init_done_in && cfg_in[g].enable && cfg_in[g].mode == MODE_ALERT;
		AST_GP_OUT: assert property (act && cfg_in[g].mode == MODE_GP_OUT && !cfg_in[g].open_drain
			|=> pin_out[g] == $past(cfg_in[g].out_level) && !pin_oe_n_out[g]) else $error("gp out");
		AST_OD: assert property (act && cfg_in[g].open_drain |=> !(pin_out[g] && !pin_oe_n_out[g]))
			else $error("open drain");
		AST_LOS: assert property (act && cfg_in[g].mode == MODE_LOS
			|=> pin_out[g] == $past(live_in.los[cfg_in[g].sel] ^ cfg_in[g].invert)) else $error("los");
		AST_ALERT: assert property ($past(alr) && alr && $stable(cfg_in[g]) && $past(ce_in)
			|-> pin_out[g] == (|(sticky_out & cfg_in[g].alert_mask) ^ cfg_in[g].invert)) else $error("alert");
	end
	for (genvar b = 0; b < NUM_STICKY; b++) begin : g_stk
		sequence clr3;
			(sticky_clear_in[b] && ce_in && !chg[b]) [*3];
		endsequence
		AST_SET: assert property (ce_in && alarm_en_in && chg[b] && !sticky_clear_in[b] |-> ##[1:2] sticky_out[b])
			else $error("sticky set");
		AST_HOLD: assert property (sticky_out[b] && !sticky_clear_in[b] && !$past(sticky_clear_in[b])
			|=> sticky_out[b]) else $error("sticky hold");
		AST_CLEAR: assert property (clr3 |=> !sticky_out[b]) else $error("sticky clear");
	end
endmodule
bind gpio_bank gpio_bank_chk gpio_bank_chk_i (.core_clk_in, .rst_in, .ce_in, .init_done_in, .cfg_in, .alarm_en_in,
	.sticky_clear_in, .live_in, .pin_out, .pin_oe_n_out, .sticky_out, .loop_ctl_out);

// [verification/tb_top.sv]
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
	$display("ERROR %s exp %0h got %0h", n, e, g); end end
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import gpio_pkg::*;
	logic	core_clk_in = 1'b0;
	logic	rst_in = 1'b1;
	logic	init_done_in = 1'b0;
	logic	alarm_en_in = 1'b1;
	logic [1:0]	vdd_sel_in = VDD_3V3;
	logic [1:0]	vdd_level_out;
	logic [NUM_STICKY-1:0]	sticky_clear_in = '0;
	logic [NUM_STICKY-1:0]	sticky_out;
	logic [LOOP_W-1:0]	loop_sel_in [NUM_PINS];
	pin_cfg_t	cfg_in [NUM_PINS];
	alarm_live_t	live_in = '0;
	logic [NUM_PINS-1:0]	drv = '0;
	logic [NUM_PINS-1:0]	drv_en = 16'h00E0;
	logic [NUM_PINS-1:0]	pin_in, pin_out, pin_oe_n_out, pin_pull_up_out, pin_status_out, pin_pull_en_out, clk_in_pin_out;
	logic [NUM_OUTS-1:0]	clk_out_dis_out;
	logic	ce_in = 1'b1;
	logic [NUM_STAGES-1:0]	stage_full = '0;
	logic [NUM_STAGES-1:0]	clk_in_sel_out;
	loop_ctl_t	loop_ctl_out;
	logic [3:0]	cnt;
	int	error_cnt = 0;
	int	total_checks = 0;
	always #50 core_clk_in = ~core_clk_in;
	gpio_bank gpio_bank_i (.core_clk_in, .rst_in, .ce_in, .init_done_in, .cfg_in, .vdd_sel_in, .alarm_en_in,
		.sticky_clear_in, .stage_full_in(stage_full), .loop_sel_in, .live_in, .pin_in, .pin_out, .pin_oe_n_out,
		.pin_pull_up_out, .pin_pull_en_out, .vdd_level_out, .pin_status_out, .sticky_out, .clk_out_dis_out,
		.clk_in_sel_out, .clk_in_pin_out, .loop_ctl_out);
	board_model board_model_i (.pin_out_in(pin_out), .oe_n_in(pin_oe_n_out), .pull_up_in(pin_pull_up_out),
		.drv_in(drv), .drv_en_in(drv_en), .wire_out(pin_in));
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk_in);
		#1;
	endtask
	task automatic tend(input string s);
		$display("test %s done", s);
	endtask
	task automatic setp(input int p, input pin_mode_t m, input logic [NUM_OUTS-1:0] om, input logic [NUM_STICKY-1:0] am);
		cfg_in[p].mode = m;
		cfg_in[p].out_mask = om;
		cfg_in[p].alert_mask = am;
	endtask
	task automatic clr(input int b);
		sticky_clear_in[b] = 1'b1;
		cyc(3);
		sticky_clear_in = '0;
		cyc(2);
	endtask
	task automatic test_done;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		#100_000;
		error_cnt++;
		test_done;
	end
	initial begin
		for (int i = 0; i < NUM_PINS; i++) begin
			cfg_in[i] = '0;
			cfg_in[i].enable = 1'b1;
			cfg_in[i].pull_up = 1'b1;
			loop_sel_in[i] = 3'h2;
		end
		setp(0, MODE_GP_OUT, '0, '0);
		setp(1, MODE_LOS, '0, '0);
		setp(2, MODE_LOS, '0, '0);
		setp(3, MODE_LOL_STICKY, '0, '0);
		setp(4, MODE_ALERT, '0, 32'h0008_0000);
		setp(5, MODE_OUT_DIS, 16'h00F0, '0);
		setp(6, MODE_DCO_INC, '0, '0);
		setp(10, MODE_CLK_IN, '0, '0);
		setp(11, MODE_MAN_SEL, '0, '0);
		setp(12, MODE_DISQUAL, '0, '0);
		setp(13, MODE_DCO_DEC, '0, '0);
		setp(14, MODE_HO_STICKY, '0, '0);
		setp(15, MODE_HO_LIVE, '0, '0);
		cfg_in[10].sel = 4'h5;
		cfg_in[13].pull_up = 1'b0;
		cfg_in[0].out_level = 1'b1;
		cfg_in[1].sel = 4'h3;
		cfg_in[2].sel = 4'h3;
		cyc(3);
		rst_in = 1'b0;
		cyc(2);
		`CHK("oe_n", '1, pin_oe_n_out)
		init_done_in = 1'b1;
		vdd_sel_in = VDD_1V8;
		cyc(2);
		`CHK("gp out", 2'h2, {pin_out[0], pin_oe_n_out[0]})
		`CHK("vdd", VDD_1V8, vdd_level_out)
		cfg_in[0].open_drain = 1'b1;
		cyc(2);
		`CHK("od high", 2'h3, {pin_oe_n_out[0], pin_in[0]})
		cfg_in[0].out_level = 1'b0;
		cyc(2);
		`CHK("od low", 2'h0, {pin_oe_n_out[0], pin_in[0]})
		ce_in = 1'b0;
		cfg_in[0].out_level = 1'b1;
		cyc(2);
		`CHK("freeze", 2'h0, {pin_out[0], pin_oe_n_out[0]})
		ce_in = 1'b1;
		cyc(2);
		`CHK("thaw", 2'h3, {pin_out[0], pin_oe_n_out[0]})
		drv[7] = 1'b1;
		cfg_in[8].pull_up = 1'b0;
		cyc(5);
		`CHK("inputs", 4'h9, {pin_status_out[7], pin_pull_up_out[8], pin_status_out[8], pin_status_out[9]})
		`CHK("pull en", 16'hFFFF, pin_pull_en_out)
		tend("levels");
		live_in.los[3] = 1'b1;
		cyc(3);
		`CHK("los", 2'h3, pin_out[2:1])
		`CHK("alert", 2'h3, {sticky_out[19], pin_out[4]})
		cfg_in[2].invert = 1'b1;
		live_in.los[3] = 1'b0;
		cyc(2);
		`CHK("los inv", 2'h2, pin_out[2:1])
		clr(19);
		`CHK("clear", 2'h0, {sticky_out[19], pin_out[4]})
		alarm_en_in = 1'b0;
		live_in.los[3] = 1'b1;
		cyc(3);
		`CHK("mask", 16'h0000, sticky_out[31:16])
		alarm_en_in = 1'b1;
		live_in.unlocked[2] = 1'b1;
		cyc(3);
		live_in.unlocked[2] = 1'b0;
		cyc(3);
		`CHK("lol", 1'b1, pin_out[3])
		clr(10);
		`CHK("lol clr", 1'b0, pin_out[3])
		cfg_in[3].invert = 1'b1;
		cyc(2);
		`CHK("lol inv", 1'b1, pin_out[3])
		live_in.holdover[2] = 1'b1;
		cyc(3);
		`CHK("ho", 3'h7, {pin_out[15], pin_out[14], sticky_out[2]})
		cfg_in[14].invert = 1'b1;
		cfg_in[15].mode = MODE_LOL_LIVE;
		live_in.holdover[2] = 1'b0;
		cyc(3);
		clr(2);
		`CHK("ho clr", 3'h4, {pin_out[14], pin_out[15], sticky_out[2]})
		live_in.unlocked[2] = 1'b1;
		cyc(2);
		`CHK("lol live", 1'b1, pin_out[15])
		tend("alarms");
		drv[6:5] = 2'h3;
		cnt = '0;
		repeat (8) begin
			cyc(1);
			cnt = cnt + {3'h0, loop_ctl_out.inc[2]};
		end
		`CHK("inc", 4'h1, cnt)
		`CHK("dis", 16'h00F0, clk_out_dis_out)
		drv[5] = 1'b0;
		cyc(4);
		`CHK("en", 16'h0000, clk_out_dis_out)
		`CHK("clk in", 2'h3, {clk_in_sel_out[5], clk_in_pin_out[10]})
		stage_full = 8'h20;
		cyc(2);
		`CHK("stage full", 2'h0, {clk_in_sel_out[5], clk_in_pin_out[10]})
		`CHK("man sel", 2'h3, {loop_ctl_out.man_high[2], loop_ctl_out.disqual[2]})
		cfg_in[11].pull_up = 1'b0;
		cfg_in[12].pull_up = 1'b0;
		cfg_in[13].pull_up = 1'b1;
		cnt = '0;
		repeat (8) begin
			cyc(1);
			cnt = cnt + {3'h0, loop_ctl_out.dec[2]};
		end
		`CHK("dec", 4'h1, cnt)
		`CHK("man low", 2'h0, {loop_ctl_out.man_high[2], loop_ctl_out.disqual[2]})
		tend("controls");
		test_done;
	end
endmodule
